// >>> ssp_cfg.svh
// Purpose: Constants for the spindle stop position select block
// Assumes: AXI4-Lite byte addresses, 32-bit data
// Notes: Offsets, reset values, function codes and field positions
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define SSP_OFF_CTRL 8'h00
`define SSP_OFF_INTPOS 8'h04
`define SSP_OFF_MODE 8'h08
`define SSP_OFF_SHIFT 8'h0c
`define SSP_OFF_LINES 8'h10
`define SSP_OFF_INPOS 8'h14
`define SSP_OFF_OPTCFG 8'h18
`define SSP_OFF_STATUS 8'h1c
`define SSP_OFF_MONITOR 8'h20
`define SSP_OFF_WORD 8'h24
`define SSP_OFF_MAP 8'h40
`define SSP_MAP_WORDS 3'h5
// ------------------------------------------------------------
// Reset values and fields
// ------------------------------------------------------------
`define SSP_RST_LINES 13'h0400
`define SSP_RST_INPOS 16'h0005
`define SSP_RST_SHIFT 14'h0000
`define SSP_MAP_NONE 8'hff
`define SSP_CTRL_SRC 0
`define SSP_CTRL_OPT 1
`define SSP_CTRL_VEC 2
`define SSP_CTRL_ENC 3
`define SSP_CTRL_OEN 4
`define SSP_CTRL_MON 8
// ------------------------------------------------------------
// Terminal function codes and monitor items
// ------------------------------------------------------------
`define SSP_FN_ORIENT 8'h16
`define SSP_FN_DONE 8'h1b
`define SSP_FN_DONE_N 8'h7f
`define SSP_FN_FAULT 8'h1c
`define SSP_FN_FAULT_N 8'h80
`define SSP_MON_RAW 8'h13
`define SSP_N_IN 12
`define SSP_N_OUT 7
`define SSP_N_MAP 20
`define SSP_RESP_OKAY 2'h0
`define SSP_RESP_SLVERR 2'h2
`endif

// >>> ssp_pkg.sv
// Purpose: Types for the spindle stop position select block
// Assumes: Constants live in ssp_cfg.svh
// Notes: Mode classes of the external word
package ssp_pkg;
   typedef enum logic [1:0] {
      SSP_MODE_SPEED = 2'b00,
      SSP_MODE_DIRECT = 2'b01,
      SSP_MODE_DIVIDED = 2'b10
   } ssp_mode_e;
   typedef logic [15:0] ssp_word_t;
   typedef logic [7:0] ssp_code_t;
endpackage : ssp_pkg

// >>> ssp_stop_select.sv
// Purpose: Stop position selection, shaping and orientation result outputs
// Assumes: Encoder position, rest flag and direction come from logic on clk_sys_i
// Notes: Registers over AXI4-Lite; pins pass a two-stage synchroniser
`timescale 1ns/100ps
`include "ssp_cfg.svh"

// Summary of operation
// - Done output asserts when shaft rests inside zone with run and request active.
// - Fault output asserts when shaft rests outside zone with run and request active.
// - Input terminal carrying function code 22 supplies the orientation request.
// - Output terminal code 27 drives done, code 127 drives it inverted.
// - Output terminal code 28 drives fault, code 128 drives it inverted.
// - Source select 0 picks internal position, 1 picks external word.
// - Addresses are quadrature counts; revolution spans four times line count.
// - Word mode 0 makes the external word a speed or torque command.
// - Word mode 1 uses the word directly, saturating at the largest address.
// - Word mode 2 to 127 divides one revolution into equal stop positions.
// - Divided index above the setting gives the maximum index position.
// - Absent option or mode 0 gives stop position 0 with external source.
// - Word modes 1 to 127 take speed from normal input, not the word.
// - Final stop position is command plus shift, shift resets to 0.
// - Option card settings apply only while word mode is 0.
// - In vector control the strobe is ignored; word captured at orientation start.
// - Monitor item 19 shows raw encoder pulses, not stop index.
// - With orientation and encoder fitted, show sensed rotation direction.
// - Done and fault go inactive one cycle after the request goes inactive.
// - Shaft in position when within plus or minus zone width, default 5.
module ssp_stop_select
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // AXI4-Lite write channels
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // AXI4-Lite read channels
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Controller pins
   input wire logic [`SSP_N_IN-1:0] term_in_i,
   input wire logic run_forward_in_i,
   input wire logic run_reverse_in_i,
   input wire logic word_read_strobe_i,
   input wire ssp_pkg::ssp_word_t ext_word_i,
   // Encoder side
   input wire ssp_pkg::ssp_word_t encoder_pos_i,
   input wire logic shaft_at_rest_i,
   input wire logic encoder_dir_rev_i,
   // Results
   output logic [`SSP_N_OUT-1:0] term_out_o,
   output logic orient_done_out_o,
   output logic orient_fault_out_o,
   output ssp_pkg::ssp_word_t stop_pos_o,
   output ssp_pkg::ssp_word_t monitor_o,
   output ssp_pkg::ssp_word_t speed_word_o,
   output logic speed_from_word_o,
   output logic [31:0] opt_cfg_o,
   output logic dir_fwd_o,
   output logic dir_rev_o
);
   import ssp_pkg::*;

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   function automatic logic [31:0] ssp_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
            res[8*b +: 8] = new_v[8*b +: 8];
      end
      return res;
   endfunction : ssp_merge

   function automatic logic [14:0] ssp_mod(input logic [16:0] v, input logic [14:0] m);
      logic [16:0] r;
      r = (m == 15'h0000) ? 17'h00000 : v % {2'b00, m};
      return r[14:0];
   endfunction : ssp_mod

   function automatic logic [14:0] ssp_dist(input logic [14:0] a, input logic [14:0] b,
                                            input logic [14:0] m);
      logic [14:0] d;
      d = (a >= b) ? a - b : b - a;
      return ((m - d) < d) ? m - d : d;
   endfunction : ssp_dist

   function automatic logic ssp_has(input ssp_code_t code, input ssp_code_t want);
      return code == want;
   endfunction : ssp_has

   // ------------------------------------------------------------
   // Bus and register state
   // ------------------------------------------------------------
   logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
   logic [7:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [7:0] ctrl_r, ctrl_nxt, mon_sel_r, mon_sel_nxt;
   logic [13:0] int_pos_r, int_pos_nxt, shift_r, shift_nxt;
   logic [6:0] mode_r, mode_nxt;
   logic [12:0] line_r, line_nxt;
   logic [15:0] inpos_r, inpos_nxt;
   logic [31:0] opt_cfg_r, opt_cfg_nxt;
   ssp_code_t map_r [0:`SSP_N_MAP-1];
   ssp_code_t map_nxt [0:`SSP_N_MAP-1];
   logic wr_go, wr_hit, rd_hit;
   logic [31:0] rd_word, wr_old, wr_val, status_w;
   logic [2:0] map_k;

   // Datapath state, declared here for the read mux
   ssp_word_t word_hold_r, word_hold_nxt, stop_pos_r, stop_pos_nxt;
   ssp_word_t monitor_r, monitor_nxt;
   logic done_r, done_nxt, fault_r, fault_nxt, orient_req;

   assign wr_go = aw_have_r & w_have_r & ~bvalid_r;
   assign s_axi_awready_o = ~aw_have_r & ~bvalid_r;
   assign s_axi_wready_o = ~w_have_r & ~bvalid_r;
   assign s_axi_arready_o = ~rvalid_r;
   assign s_axi_bvalid_o = bvalid_r;
   assign s_axi_bresp_o = bresp_r;
   assign s_axi_rvalid_o = rvalid_r;
   assign s_axi_rdata_o = rdata_r;
   assign s_axi_rresp_o = rresp_r;
   assign status_w = {8'h00, dir_rev_o, dir_fwd_o, orient_req, fault_r, done_r,
                      3'h0, stop_pos_r};

   always_comb
   begin
      map_k = 3'(s_axi_araddr_i[4:2]);
      rd_hit = 1'b1;
      rd_word = 32'h00000000;
      unique case (s_axi_araddr_i)
         `SSP_OFF_CTRL: rd_word = {16'h0000, mon_sel_r, ctrl_r};
         `SSP_OFF_INTPOS: rd_word = {18'h00000, int_pos_r};
         `SSP_OFF_MODE: rd_word = {25'h0000000, mode_r};
         `SSP_OFF_SHIFT: rd_word = {18'h00000, shift_r};
         `SSP_OFF_LINES: rd_word = {19'h00000, line_r};
         `SSP_OFF_INPOS: rd_word = {16'h0000, inpos_r};
         `SSP_OFF_OPTCFG: rd_word = opt_cfg_r;
         `SSP_OFF_STATUS: rd_word = status_w;
         `SSP_OFF_MONITOR: rd_word = {16'h0000, monitor_r};
         `SSP_OFF_WORD: rd_word = {16'h0000, word_hold_r};
         default:
         begin
            rd_hit = (s_axi_araddr_i[7:5] == `SSP_OFF_MAP >> 5) &&
                     (s_axi_araddr_i[1:0] == 2'h0) && (map_k < `SSP_MAP_WORDS);
            if (rd_hit)
               rd_word = {map_r[4*map_k+3], map_r[4*map_k+2],
                          map_r[4*map_k+1], map_r[4*map_k]};
         end
      endcase
   end

   always_comb
   begin
      aw_have_nxt = aw_have_r;
      w_have_nxt = w_have_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r & ~s_axi_bready_i;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r & ~s_axi_rready_i;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      ctrl_nxt = ctrl_r;
      mon_sel_nxt = mon_sel_r;
      int_pos_nxt = int_pos_r;
      mode_nxt = mode_r;
      shift_nxt = shift_r;
      line_nxt = line_r;
      inpos_nxt = inpos_r;
      opt_cfg_nxt = opt_cfg_r;
      map_nxt = map_r;
      wr_hit = 1'b1;
      wr_old = 32'h00000000;
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
         aw_have_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
         w_have_nxt = 1'b1;
         wdata_nxt = s_axi_wdata_i;
         wstrb_nxt = s_axi_wstrb_i;
      end
      unique case (awaddr_r)
         `SSP_OFF_CTRL: wr_old = {16'h0000, mon_sel_r, ctrl_r};
         `SSP_OFF_INTPOS: wr_old = {18'h00000, int_pos_r};
         `SSP_OFF_MODE: wr_old = {25'h0000000, mode_r};
         `SSP_OFF_SHIFT: wr_old = {18'h00000, shift_r};
         `SSP_OFF_LINES: wr_old = {19'h00000, line_r};
         `SSP_OFF_INPOS: wr_old = {16'h0000, inpos_r};
         `SSP_OFF_OPTCFG: wr_old = opt_cfg_r;
         default: wr_hit = (awaddr_r[7:5] == `SSP_OFF_MAP >> 5) &&
                           (awaddr_r[1:0] == 2'h0) && (awaddr_r[4:2] < `SSP_MAP_WORDS);
      endcase
      wr_val = ssp_merge(wr_old, wdata_r, wstrb_r);
      if (wr_go)
      begin
         aw_have_nxt = 1'b0;
         w_have_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = wr_hit ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
         unique case (awaddr_r)
            `SSP_OFF_CTRL:
            begin
               ctrl_nxt = wr_val[7:0];
               mon_sel_nxt = wr_val[15:8];
            end
            `SSP_OFF_INTPOS: int_pos_nxt = wr_val[13:0];
            `SSP_OFF_MODE: mode_nxt = wr_val[6:0];
            `SSP_OFF_SHIFT: shift_nxt = wr_val[13:0];
            `SSP_OFF_LINES: line_nxt = wr_val[12:0];
            `SSP_OFF_INPOS: inpos_nxt = wr_val[15:0];
            `SSP_OFF_OPTCFG: opt_cfg_nxt = wr_val;
            default:
            begin
               for (int i = 0; i < `SSP_N_MAP; i++)
               begin
                  if (wr_hit && awaddr_r[4:2] == 3'(i / 4) && wstrb_r[i % 4])
                     map_nxt[i] = wdata_r[8*(i % 4) +: 8];
               end
            end
         endcase
      end
      if (s_axi_arvalid_i && s_axi_arready_o)
      begin
         rvalid_nxt = 1'b1;
         rdata_nxt = rd_word;
         rresp_nxt = rd_hit ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= `SSP_RESP_OKAY;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= `SSP_RESP_OKAY;
         ctrl_r <= 8'h00;
         mon_sel_r <= 8'h00;
         int_pos_r <= 14'h0000;
         mode_r <= 7'h00;
         shift_r <= `SSP_RST_SHIFT;
         line_r <= `SSP_RST_LINES;
         inpos_r <= `SSP_RST_INPOS;
         opt_cfg_r <= 32'h00000000;
         for (int i = 0; i < `SSP_N_MAP; i++)
            map_r[i] <= `SSP_MAP_NONE;
      end
      else
      begin
         aw_have_r <= aw_have_nxt;
         w_have_r <= w_have_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
         ctrl_r <= ctrl_nxt;
         mon_sel_r <= mon_sel_nxt;
         int_pos_r <= int_pos_nxt;
         mode_r <= mode_nxt;
         shift_r <= shift_nxt;
         line_r <= line_nxt;
         inpos_r <= inpos_nxt;
         opt_cfg_r <= opt_cfg_nxt;
         map_r <= map_nxt;
      end
   end

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [`SSP_N_IN+18:0] pin_s1_r, pin_s2_r;
   logic [`SSP_N_IN-1:0] term_s;
   logic run_fwd_s, run_rev_s, strobe_s, orient_q_r;
   ssp_word_t word_s;

   assign {term_s, run_fwd_s, run_rev_s, strobe_s, word_s} = pin_s2_r;

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         orient_q_r <= 1'b0;
      end
      else
      begin
         pin_s1_r <= {term_in_i, run_forward_in_i, run_reverse_in_i,
                      word_read_strobe_i, ext_word_i};
         pin_s2_r <= pin_s1_r;
         orient_q_r <= orient_req;
      end
   end

   // ------------------------------------------------------------
   // Position command datapath
   // ------------------------------------------------------------
   ssp_mode_e mode_cls;
   logic [14:0] rev, max_addr, stop_w, enc_w;
   logic [6:0] div_idx;
   logic [21:0] div_prod;
   ssp_word_t cmd;
   logic src_ext, opt_fit, vec_mode, orient_rise, in_zone, run_on, capture;
   logic [`SSP_N_OUT-1:0] term_out_r, term_out_nxt;
   logic spd_r, spd_nxt, dfw_r, dfw_nxt, drv_r, drv_nxt;
   ssp_word_t spw_r, spw_nxt;
   logic [31:0] ocf_r, ocf_nxt;

   assign src_ext = ctrl_r[`SSP_CTRL_SRC];
   assign opt_fit = ctrl_r[`SSP_CTRL_OPT];
   assign vec_mode = ctrl_r[`SSP_CTRL_VEC];
   assign orient_rise = orient_req & ~orient_q_r;
   assign run_on = run_fwd_s | run_rev_s;

   always_comb
   begin
      orient_req = 1'b0;
      for (int i = 0; i < `SSP_N_IN; i++)
         orient_req = orient_req | (term_s[i] & ssp_has(map_r[i], `SSP_FN_ORIENT));
      rev = {line_r, 2'b00};
      max_addr = rev - 15'h0001;
      unique case (mode_r)
         7'h00: mode_cls = SSP_MODE_SPEED;
         7'h01: mode_cls = SSP_MODE_DIRECT;
         default: mode_cls = SSP_MODE_DIVIDED;
      endcase
      capture = vec_mode ? orient_rise : strobe_s;
      word_hold_nxt = capture ? word_s : word_hold_r;
      div_idx = (word_hold_r > {9'h000, mode_r}) ? mode_r : word_hold_r[6:0];
      div_prod = 22'(rev) * 22'(div_idx);
      cmd = 16'h0000;
      if (!src_ext)
         cmd = {2'b00, int_pos_r};
      else if (opt_fit)
      begin
         unique case (mode_cls)
            SSP_MODE_SPEED: cmd = 16'h0000;
            SSP_MODE_DIRECT: cmd = (word_hold_r > {1'b0, max_addr}) ?
                                   {1'b0, max_addr} : word_hold_r;
            SSP_MODE_DIVIDED: cmd = 16'(div_prod /
                                   {14'h0000, {1'b0, mode_r} + 8'h01});
         endcase
      end
      stop_w = ssp_mod(17'(cmd) + 17'(shift_r), rev);
      stop_pos_nxt = {1'b0, stop_w};
      enc_w = ssp_mod({1'b0, encoder_pos_i}, rev);
      in_zone = {1'b0, ssp_dist(enc_w, stop_pos_r[14:0], rev)} <= inpos_r;
      done_nxt = orient_req & run_on & shaft_at_rest_i & in_zone;
      fault_nxt = orient_req & run_on & shaft_at_rest_i & ~in_zone;
      monitor_nxt = (mon_sel_r == `SSP_MON_RAW) ? encoder_pos_i : stop_pos_r;
      for (int j = 0; j < `SSP_N_OUT; j++)
      begin
         term_out_nxt[j] = (ssp_has(map_r[`SSP_N_IN+j], `SSP_FN_DONE) & done_nxt) |
                           (ssp_has(map_r[`SSP_N_IN+j], `SSP_FN_DONE_N) & ~done_nxt) |
                           (ssp_has(map_r[`SSP_N_IN+j], `SSP_FN_FAULT) & fault_nxt) |
                           (ssp_has(map_r[`SSP_N_IN+j], `SSP_FN_FAULT_N) & ~fault_nxt);
      end
      spd_nxt = (mode_cls == SSP_MODE_SPEED);
      spw_nxt = spd_nxt ? word_hold_r : 16'h0000;
      ocf_nxt = spd_nxt ? opt_cfg_r : 32'h00000000;
      dfw_nxt = ctrl_r[`SSP_CTRL_OEN] & ctrl_r[`SSP_CTRL_ENC] & ~encoder_dir_rev_i;
      drv_nxt = ctrl_r[`SSP_CTRL_OEN] & ctrl_r[`SSP_CTRL_ENC] & encoder_dir_rev_i;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         word_hold_r <= 16'h0000;
         stop_pos_r <= 16'h0000;
         monitor_r <= 16'h0000;
         done_r <= 1'b0;
         fault_r <= 1'b0;
         term_out_r <= '0;
         spd_r <= 1'b0;
         spw_r <= 16'h0000;
         ocf_r <= 32'h00000000;
         dfw_r <= 1'b0;
         drv_r <= 1'b0;
      end
      else
      begin
         word_hold_r <= word_hold_nxt;
         stop_pos_r <= stop_pos_nxt;
         monitor_r <= monitor_nxt;
         done_r <= done_nxt;
         fault_r <= fault_nxt;
         term_out_r <= term_out_nxt;
         spd_r <= spd_nxt;
         spw_r <= spw_nxt;
         ocf_r <= ocf_nxt;
         dfw_r <= dfw_nxt;
         drv_r <= drv_nxt;
      end
   end

   assign term_out_o = term_out_r;
   assign orient_done_out_o = done_r;
   assign orient_fault_out_o = fault_r;
   assign stop_pos_o = stop_pos_r;
   assign monitor_o = monitor_r;
   assign speed_word_o = spw_r;
   assign speed_from_word_o = spd_r;
   assign opt_cfg_o = ocf_r;
   assign dir_fwd_o = dfw_r;
   assign dir_rev_o = drv_r;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   a_done_in_zone: assert property (orient_req && run_on && shaft_at_rest_i && in_zone
      |=> orient_done_out_o && !orient_fault_out_o) else $error("done not raised");
   a_fault_out_zone: assert property (orient_req && run_on && shaft_at_rest_i && !in_zone
      |=> orient_fault_out_o && !orient_done_out_o) else $error("fault not raised");
   a_idle_quiet: assert property (!orient_req [*2]
      |-> !orient_done_out_o && !orient_fault_out_o) else $error("result while idle");
   a_stop_wrap: assert property (rev != 15'h0000 |=> stop_pos_o < {1'b0, $past(rev)})
      else $error("stop position outside revolution");
   a_direct_sat: assert property (src_ext && opt_fit && mode_r == 7'h01 && shift_r == 14'h0
      && word_hold_r > {1'b0, max_addr} |=> stop_pos_o == {1'b0, $past(max_addr)})
      else $error("direct word not saturated");
   a_absent_zero: assert property (src_ext && !opt_fit && shift_r == 14'h0
      |=> stop_pos_o == 16'h0000) else $error("stop not zero without option");
   a_vector_hold: assert property (vec_mode && !orient_rise |=> $stable(word_hold_r))
      else $error("word captured outside orientation start");
   a_cfg_gate: assert property (mode_r != 7'h00 |=> opt_cfg_o == 32'h0 && !speed_from_word_o)
      else $error("option settings leak");
   a_monitor_raw: assert property (mon_sel_r == `SSP_MON_RAW && $stable(mon_sel_r)
      |=> monitor_o == $past(encoder_pos_i)) else $error("monitor not raw");
   a_term_done: assert property (ssp_has(map_r[`SSP_N_IN], `SSP_FN_DONE)
      && $stable(map_r[`SSP_N_IN]) |-> term_out_o[0] == orient_done_out_o)
      else $error("terminal does not follow done");
   a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
      else $error("write response dropped");

   c_done_seen: cover property (orient_req ##[1:50] orient_done_out_o);
   c_fault_seen: cover property (orient_req ##[1:50] orient_fault_out_o);
   c_divided_use: cover property (src_ext && opt_fit && mode_cls == SSP_MODE_DIVIDED);
   c_vector_cap: cover property (vec_mode && orient_rise);

endmodule : ssp_stop_select

// >>> ssp_ctrl_model.sv
// Purpose: Machine controller model driving the orientation pins
// Assumes: Pins change just after a rising edge
// Notes: Word lines show the inverse of the last word while strobe is low
`timescale 1ns/100ps
module ssp_ctrl_model
(
   // Commands from the bench
   input wire logic clk_sys_i,
   input wire logic req_i,
   input wire logic run_i,
   input wire logic load_i,
   input wire logic [15:0] word_i,
   // Controller pins
   output logic [11:0] term_in_o,
   output logic run_forward_in_o,
   output logic run_reverse_in_o,
   output logic word_read_strobe_o,
   output logic [15:0] ext_word_o
);
   always_ff @(posedge clk_sys_i)
   begin
      term_in_o <= {6'h00, req_i, 5'h00};
      run_forward_in_o <= run_i;
      run_reverse_in_o <= 1'b0;
      word_read_strobe_o <= load_i;
      ext_word_o <= load_i ? word_i : ~word_i;
   end
endmodule : ssp_ctrl_model

// >>> ssp_tb.sv
// Purpose: Self-checking bench for the stop position select block
// Assumes: Default encoder line count, pins through the controller model
// Notes: Random positions, shifts and words from a fixed seed
`timescale 1ns/100ps
`include "ssp_cfg.svh"
module tb;
   import ssp_pkg::*;
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic awready, wready, bvalid, arready, rvalid, done, fault, sfw;
   logic [1:0] bresp, rresp, rr;
   logic req = 1'b0, run = 1'b0, load = 1'b0, rest = 1'b0;
   logic [15:0] word = 16'h0, enc = 16'h0, ew;
   logic [11:0] tin;
   logic fwd, rev, stb, dfw, drv, dirr = 1'b0;
   logic [6:0] tout;
   logic [13:0] ip, sh;
   logic [6:0] modes [6] = '{7'd1, 7'd0, 7'd1, 7'd2, 7'd89, 7'd127};
   ssp_word_t stop;
   ssp_word_t mon;
   ssp_word_t spw;
   logic [31:0] ocf;
   int failures = 0, num_checks = 0, e, i;
   always #4 clk_sys_i = ~clk_sys_i;
   ssp_ctrl_model u_ssp_ctrl_model (.clk_sys_i(clk_sys_i), .req_i(req), .run_i(run),
      .load_i(load), .word_i(word), .term_in_o(tin), .run_forward_in_o(fwd),
      .run_reverse_in_o(rev), .word_read_strobe_o(stb), .ext_word_o(ew));
   ssp_stop_select u_ssp_stop_select (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .term_in_i(tin),
      .run_forward_in_i(fwd), .run_reverse_in_i(rev), .word_read_strobe_i(stb),
      .ext_word_i(ew), .encoder_pos_i(enc), .shaft_at_rest_i(rest),
      .encoder_dir_rev_i(dirr), .term_out_o(tout), .orient_done_out_o(done),
      .orient_fault_out_o(fault), .stop_pos_o(stop), .monitor_o(mon), .speed_word_o(spw),
      .speed_from_word_o(sfw), .opt_cfg_o(ocf), .dir_fwd_o(dfw), .dir_rev_o(drv));
   task automatic final_report;
      begin
         $display("checks %0d failures %0d", num_checks, failures);
         if (failures == 0 && num_checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask : final_report
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      begin
         num_checks++;
         if (g !== x)
         begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
         end
      end
   endtask : chk
   task automatic guard(input int n);
      begin
         if (n >= 40)
         begin
            failures++;
            final_report();
         end
      end
   endtask : guard
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      begin
         n = 0;
         @(posedge clk_sys_i);
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         do
         begin
            @(posedge clk_sys_i);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            n++;
         end
         while (bvalid !== 1'b1 && n < 40);
         bready <= 1'b0;
         guard(n);
      end
   endtask : wr
   task automatic rdw(input logic [7:0] a);
      int n;
      begin
         n = 0;
         @(posedge clk_sys_i);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do
         begin
            @(posedge clk_sys_i);
            if (arready === 1'b1) arvalid <= 1'b0;
            n++;
         end
         while (rvalid !== 1'b1 && n < 40);
         rd = rdata;
         rr = rresp;
         rready <= 1'b0;
         guard(n);
      end
   endtask : rdw
   task automatic settle;
      repeat (6) @(posedge clk_sys_i);
   endtask : settle
   function automatic int exp_pos(input logic [1:0] c, input logic [6:0] m, input logic [15:0] w);
      int k;
      begin
         k = (w > m) ? m : w;
         if (c != 2'b11 || m == 0) return 0;
         if (m == 1) return (w > 4095) ? 4095 : w;
         return (4096 * k) / (m + 1);
      end
   endfunction : exp_pos
   initial
   begin
      void'($urandom(32'h3541a900));
      repeat (10) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      rdw(`SSP_OFF_LINES);
      chk(rd, 32'h400);
      rdw(`SSP_OFF_INPOS);
      chk(rd, 32'h5);
      rdw(`SSP_OFF_SHIFT);
      chk(rd, 32'h0);
      rdw(8'h30);
      chk(rr, `SSP_RESP_SLVERR);
      wr(8'h44, 32'hffff16ff);
      wr(8'h4c, 32'h801c7f1b);
      ip = 14'($urandom);
      sh = 14'($urandom);
      wr(`SSP_OFF_INTPOS, ip);
      wr(`SSP_OFF_SHIFT, sh);
      wr(`SSP_OFF_CTRL, 32'h1318);
      e = (int'(ip) + int'(sh)) % 4096;
      settle;
      chk(stop, e);
      enc <= 16'(e + 3);
      req <= 1'b1;
      run <= 1'b1;
      rest <= 1'b1;
      settle;
      chk({fault, done, tout[3:0]}, 6'h19);
      chk(mon, enc);
      chk({dfw, drv}, 2'b10);
      enc <= 16'(e + 6);
      dirr <= 1'b1;
      settle;
      chk({fault, done, tout[3:0]}, 6'h26);
      chk({dfw, drv}, 2'b01);
      req <= 1'b0;
      settle;
      chk({fault, done, tout[3:0]}, 6'h0a);
      wr(`SSP_OFF_SHIFT, 32'h0);
      wr(`SSP_OFF_OPTCFG, 32'h5a5a00c3);
      for (i = 0; i < 6; i++)
      begin
         wr(`SSP_OFF_CTRL, (i == 0) ? 32'h1 : 32'h3);
         wr(`SSP_OFF_MODE, modes[i]);
         word <= (i == 2) ? 16'hffff : 16'($urandom);
         load <= 1'b1;
         settle;
         load <= 1'b0;
         settle;
         e = exp_pos((i == 0) ? 2'b01 : 2'b11, modes[i], word);
         chk(stop, e);
         chk(sfw, modes[i] == 0);
         chk(spw, (modes[i] == 0) ? word : 16'h0000);
         chk(ocf, (modes[i] == 0) ? 32'h5a5a00c3 : 32'h0);
      end
      wr(`SSP_OFF_CTRL, 32'h7);
      word <= 16'h0005;
      load <= 1'b1;
      settle;
      chk(stop, e);
      req <= 1'b1;
      settle;
      chk(stop, exp_pos(2'b11, 7'h7f, 16'h0005));
      final_report();
   end
endmodule : tb
